// ---- common/formatter_pkg.sv ----
/*
 * Constants, field layouts and carrier types for the ADC output gain
 * and format block.
 * Assumes a 32-bit APB register bus and a 12-bit serial lane word.
 */
// Summary of operation
// - Coarse/fine coefficient pair sets digital gain; 111/110 is 0 dB, 010/010 4.16 dB.
// - Control bit 4 enables the equalizer, cutting group delay; clear keeps it off.
// - Control bit 3 clear gives two's complement output, set gives offset binary.
// - Control bit 2 clear sends least significant bit first, set sends most first.
// - Pattern select 00, the default, serializes filtered 12-bit sample data.
// - Any nonzero pattern select repeats a training word instead of samples.
// - Pattern 01 sends 000000111111, pattern 10 sends 010101010101, both fixed.
// - Pattern 11 sends the custom word from registers at index 08h and 09h.
// - Bit and word clocks keep running whatever the pattern select holds.
// - Digital gain compensates reduced or full input range to span full code range.
// - Coefficient codes: 010 +2, 001 +1, 000 0, 111 -1, 110 -2; 011 +2, 101/100 -2.

`default_nettype none

package formatter_pkg;

  // ****************************************************************
  // Widths and register map
  // ****************************************************************
  localparam int SAMPLE_W = 12;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] GAIN_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;
  // Custom pattern registers: index, byte address is four times it
  localparam logic [7:0] CUSTOM_LO_IDX = 8'h08;
  localparam logic [7:0] CUSTOM_HI_IDX = 8'h09;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_EQ_BIT = 4;
  localparam int CTRL_FMT_BIT = 3;
  localparam int CTRL_MSB_BIT = 2;
  localparam int CTRL_PAT_LSB = 0;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int GAIN_FINE_LSB = 0;
  localparam int GAIN_COARSE_LSB = 3;
  localparam int GAIN_RANGE_BIT = 6;
  localparam logic [6:0] GAIN_FULL_DEFAULT = 7'h3E;
  localparam logic [6:0] GAIN_REDUCED_DEFAULT = 7'h52;
  localparam int STATUS_BUSY_BIT = 1;
  localparam int STATUS_TRAIN_BIT = 0;
  localparam int STATUS_DROP_LSB = 16;

  // ****************************************************************
  // Training words and data format
  // ****************************************************************
  localparam logic [11:0] TRAIN_WORD_1 = 12'h03F;
  localparam logic [11:0] TRAIN_WORD_2 = 12'h555;
  localparam logic [11:0] OFFSET_FLIP = 12'h800;

  // ****************************************************************
  // Gain arithmetic: gain = (32 + 4a + b) / 26, 1/26 ~ 315 / 2^13
  // ****************************************************************
  localparam logic signed [6:0] GAIN_BIAS = 7'sh20;
  localparam logic [9:0] GAIN_RECIP = 10'h13B;
  localparam int GAIN_SHIFT = 13;

  typedef enum logic [1:0] {
    PAT_SAMPLE,
    PAT_TRAIN1,
    PAT_TRAIN2,
    PAT_CUSTOM
  } pattern_t;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } sample_t;

  typedef struct packed {
    logic msb_first;
    logic [SAMPLE_W-1:0] data;
  } lane_word_t;

endpackage

`default_nettype wire

// ---- dv/adc_output_gain_formatter_test.sv ----
/*
 * Self-checking bench for the output formatter: APB tasks, sample
 * and training word tests seen through the lane receiver model.
 * Assumes the design answers APB with zero wait and link_clk free running.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_output_gain_formatter_test;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, reduced_input_range, serial_data, word_clk, err;
  formatter_pkg::sample_t sample_in = '0;
  logic [11:0] rx_word, w;
  logic [6:0] gcur = 7'h3E, geff;
  int errors = 0, check_count = 0, cycles = 0;
  logic [6:0] gtab [5] = '{7'h3E, 7'h3E, 7'h1D, 7'h40, 7'h52};
  logic [4:0] ctab [5] = '{5'h00, 5'h08, 5'h04, 5'h10, 5'h0C};
  logic [11:0] xtab [5] = '{12'h100, 12'hF00, 12'h100, 12'h100, 12'h7FF};

  output_formatter output_formatter_inst (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
    .reduced_input_range(reduced_input_range), .serial_data(serial_data), .word_clk(word_clk));
  lane_receiver lane_receiver_inst (.link_clk(link_clk), .serial_data(serial_data),
    .word_clk(word_clk), .rx_word(rx_word));

  // Two unrelated clocks
  initial forever #12.5 clk = ~clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // ****************************************************************
  // Tasks and helpers
  // ****************************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait for a word on the lane, then compare
  task automatic wait_word(input logic [11:0] e);
    for (int i = 0; i < 100 && rx_word !== e; i++) @(posedge link_clk);
    check({20'h0, rx_word}, {20'h0, e});
  endtask

  function automatic logic [11:0] rev12(input logic [11:0] v);
    for (int i = 0; i < 12; i++) rev12[i] = v[11-i];
  endfunction

  // Coefficient decode, unused codes folded onto +2 and -2
  function automatic int coef(input logic [2:0] c);
    case (c)
      3'h2, 3'h3: return 2;
      3'h1: return 1;
      3'h0: return 0;
      3'h7: return -1;
      default: return -2;
    endcase
  endfunction

  // Scaled sample, saturated, format and order applied
  function automatic logic [11:0] lane_exp(input logic [6:0] g, input logic [4:0] c,
    input logic [11:0] x);
    int y;
    y = ($signed(x) * (32 + 4 * coef(g[5:3]) + coef(g[2:0])) * 315) >>> 13;
    y = y > 2047 ? 2047 : (y < -2048 ? -2048 : y);
    lane_exp = y[11:0] ^ (c[3] ? 12'h800 : 12'h000);
    if (c[2]) lane_exp = rev12(lane_exp);
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      summarize();
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h3E);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, 8'h00, 32'h1F);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1F);
    $display("test registers done");
    // Range switch loads defaults, returning restores 0 dB
    apb(1'b1, 8'h04, 32'h40);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h52);
    check({31'h0, reduced_input_range}, 32'h1);
    apb(1'b1, 8'h04, 32'h00);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h3E);
    $display("test gain range done");
    // Samples through gain, format and bit order
    for (int k = 0; k < 5; k++) begin
      geff = (gtab[k][6] != gcur[6]) ? (gtab[k][6] ? 7'h52 : 7'h3E) : gtab[k];
      gcur = geff;
      apb(1'b1, 8'h04, {25'h0, gtab[k]});
      apb(1'b1, 8'h00, {27'h0, ctab[k]});
      // Let a training word still in the hand-off clear, else the sample is dropped
      repeat (16) @(posedge clk);
      sample_in <= '{valid: 1'b1, data: xtab[k]};
      @(posedge clk);
      sample_in <= '0;
      wait_word(lane_exp(geff, ctab[k], xtab[k]));
    end
    $display("test samples done");
    // Training words in both bit orders, format bit must not alter them
    apb(1'b1, 8'h20, 32'hA5);
    apb(1'b1, 8'h24, 32'h3);
    for (int p = 1; p < 4; p++) begin
      for (int m = 0; m < 2; m++) begin
        w = (p == 1) ? 12'h03F : ((p == 2) ? 12'h555 : 12'h3A5);
        apb(1'b1, 8'h00, {27'h0, m[0], m[0], m[0], p[1:0]});
        wait_word(m[0] ? rev12(w) : w);
      end
    end
    apb(1'b1, 8'h00, 32'h0);
    $display("test training done");
    summarize();
  end
endmodule // adc_output_gain_formatter_test

`default_nettype wire

// ---- dv/lane_receiver.sv ----
/*
 * Behavioural capture logic at the far end of the serial lane.
 * Assumes word_clk rises with the first bit of each word on link_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module lane_receiver (
  input wire logic link_clk,
  input wire logic serial_data,
  input wire logic word_clk,
  output logic [11:0] rx_word
);
  // ****************************************************************
  // Word framing
  // ****************************************************************
  logic wc_q = 1'b0;
  logic [11:0] sh = 12'h000;
  int n = 0;
  // First bit lands in bit 0; framing restarts on every word clock rise
  always @(posedge link_clk) begin
    wc_q <= word_clk;
    sh = {serial_data, sh[11:1]};
    if (word_clk && !wc_q) n = 1;
    else n = n + 1;
    if (n == 12) rx_word <= sh;
  end
endmodule // lane_receiver

`default_nettype wire

// ---- dv/output_formatter_assertions.sv ----
/*
 * Concurrent checks on the output formatter ports: bus answers,
 * gain range flag and the word clock cadence on the lane.
 * Assumes the lane domain sees reset_n as a level; bound at the foot.
 */
`timescale 1ns/1ps
`default_nettype none

module formatter_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reduced_input_range,
  input wire logic word_clk
);
  // ****************************************************************
  // Bus side
  // ****************************************************************
  logic acc;
  logic mapped;
  // Access phase and decode of the five mapped words
  assign acc = psel && penable;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h0C, 8'h20, 8'h24};

  AST_READY: assert property (@(posedge clk) disable iff (!reset_n) acc |-> pready)
    else $error("access phase without ready");
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (!reset_n)
    acc && !mapped |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  AST_MAPPED: assert property (@(posedge clk) disable iff (!reset_n) acc && mapped |-> !pslverr)
    else $error("mapped access flagged");
  AST_CTRL_UPPER: assert property (@(posedge clk) disable iff (!reset_n)
    acc && !pwrite && paddr == 8'h00 |-> prdata[31:5] == 27'h0) else $error("control upper bits");
  AST_RANGE_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !(acc && pwrite && paddr == 8'h04) |=> $stable(reduced_input_range)) else $error("range moved");
  AST_RANGE_SET: assert property (@(posedge clk) disable iff (!reset_n)
    acc && pwrite && paddr == 8'h04 |=> reduced_input_range == $past(pwdata[6]))
    else $error("range flag not taken from write");
  AST_RANGE_READ: assert property (@(posedge clk) disable iff (!reset_n)
    acc && !pwrite && paddr == 8'h04 |-> prdata[6] == reduced_input_range)
    else $error("gain readback differs from range flag");

  // ****************************************************************
  // Lane side
  // ****************************************************************
  sequence high_six;
    word_clk [*6];
  endsequence
  sequence low_six;
    !word_clk [*6];
  endsequence
  AST_WORD_HIGH: assert property (@(posedge link_clk) disable iff (!reset_n)
    $rose(word_clk) |-> high_six ##1 low_six ##1 word_clk) else $error("word clock cadence");
  AST_WORD_LOW: assert property (@(posedge link_clk) disable iff (!reset_n)
    $fell(word_clk) |-> low_six ##1 high_six) else $error("word clock low phase");
endmodule // formatter_checker

bind output_formatter formatter_checker formatter_checker_inst (.clk(clk), .reset_n(reset_n),
  .link_clk(link_clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reduced_input_range(reduced_input_range), .word_clk(word_clk));

`default_nettype wire

// ---- hw/gain_scaler.sv ----
/*
 * Digital gain stage: scales a signed filter sample by the factor set by
 * a coarse and a fine coefficient, with saturation to the output width.
 * Assumes samples and coefficients on the system clock; two cycles latency.
 */
`timescale 1ns/1ps
`default_nettype none

module gain_scaler #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] coarse,
  input wire logic [2:0] fine,
  input wire formatter_pkg::sample_t sample_in,
  output formatter_pkg::sample_t sample_out
);

  // Coefficient decode; unused codes fall to the nearest end
  function automatic logic signed [2:0] coef(input logic [2:0] code);
    unique case (code)
      3'h2, 3'h3: coef = 3'sh2;
      3'h1: coef = 3'sh1;
      3'h0: coef = 3'sh0;
      3'h7: coef = -3'sh1;
      default: coef = -3'sh2;
    endcase
  endfunction

  logic signed [6:0] num;
  logic signed [W+6:0] prod_reg;
  logic valid_reg;
  logic signed [W+17:0] scaled;
  logic signed [W+17:0] max_val;
  logic signed [W+17:0] min_val;

  // Numerator 32 + 4a + b, ranges 22..42
  assign num = formatter_pkg::GAIN_BIAS + 7'(coef(coarse) * 4) + 7'(coef(fine));
  assign max_val = (W+18)'((2 ** (W - 1)) - 1);
  assign min_val = -(W+18)'(2 ** (W - 1));

  // First stage: product with the numerator
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prod_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      prod_reg <= (W+7)'($signed(sample_in.data) * num);
      valid_reg <= sample_in.valid;
    end
  end

  // Divide by 26 as a reciprocal multiply, so no divider is built
  assign scaled = ((W+18)'(prod_reg) * $signed({1'b0, formatter_pkg::GAIN_RECIP}))
                  >>> formatter_pkg::GAIN_SHIFT;

  // Second stage: saturate so gains above 0 dB clip, not wrap
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sample_out <= '0;
    end else begin
      sample_out.valid <= valid_reg;
      if (scaled > max_val) begin
        sample_out.data <= max_val[W-1:0];
      end else if (scaled < min_val) begin
        sample_out.data <= min_val[W-1:0];
      end else begin
        sample_out.data <= scaled[W-1:0];
      end
    end
  end

endmodule // gain_scaler

`default_nettype wire

// ---- hw/output_formatter.sv ----
/*
 * ADC output back end: APB control registers, digital gain, optional
 * equalizer bypass, number format and a serializer that sends sample
 * data or a repeated training word on one serial lane.
 * Assumes filtered samples arrive on clk; the lane runs on link_clk,
 * which is also the bit clock seen by the receiver.
 */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module output_formatter #(
  parameter int W = 12,
  parameter int DROP_W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire formatter_pkg::sample_t sample_in,
  output logic reduced_input_range,
  output logic serial_data,
  output logic word_clk
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam logic [7:0] CUSTOM_LO_ADDR = {formatter_pkg::CUSTOM_LO_IDX[5:0], 2'b00};
  localparam logic [7:0] CUSTOM_HI_ADDR = {formatter_pkg::CUSTOM_HI_IDX[5:0], 2'b00};
  localparam logic [3:0] LAST_BIT = 4'(W - 1);
  localparam logic [3:0] HALF_WORD = 4'(W / 2);

  logic [4:0] ctrl_reg;
  logic [6:0] gain_reg;
  logic [7:0] custom_lo_reg;
  logic [3:0] custom_hi_reg;
  logic [31:0] prdata_reg;
  logic [DROP_W-1:0] drop_count_reg;
  logic addr_hit;
  logic setup_phase;
  logic write_strobe;
  logic [31:0] read_value;
  formatter_pkg::pattern_t pattern;
  logic equalizer_on;
  logic output_number_format;
  logic msb_first;

  formatter_pkg::sample_t scaled;
  formatter_pkg::sample_t eq_stage1_reg;
  formatter_pkg::sample_t eq_stage2_reg;
  formatter_pkg::sample_t picked;
  logic [W-1:0] formatted;
  logic [W-1:0] custom_word;

  formatter_pkg::lane_word_t hold_reg;
  logic req_toggle_reg;
  logic ack_meta_reg;
  logic ack_sync_reg;
  logic busy;
  logic send;
  logic [W-1:0] send_word;

  logic rst_meta_reg;
  logic link_reset_n_reg;
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_seen_reg;
  formatter_pkg::lane_word_t pending_reg;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [W-1:0] shift_reg;
  logic [W-1:0] shift_next;
  logic order_reg;
  logic order_next;

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // Decode; unmapped addresses answer with pslverr
  always_comb begin
    unique case (paddr)
      formatter_pkg::CTRL_ADDR,
      formatter_pkg::GAIN_ADDR,
      formatter_pkg::STATUS_ADDR,
      CUSTOM_LO_ADDR,
      CUSTOM_HI_ADDR: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Zero-wait slave: read data captured in the setup cycle
  assign setup_phase = psel & ~penable;
  assign write_strobe = psel & penable & pwrite & addr_hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata = prdata_reg;

  // Read mux; control bits 7:5 always read zero
  always_comb begin
    read_value = '0;
    unique case (paddr)
      formatter_pkg::CTRL_ADDR: read_value[4:0] = ctrl_reg;
      formatter_pkg::GAIN_ADDR: read_value[6:0] = gain_reg;
      CUSTOM_LO_ADDR: read_value[7:0] = custom_lo_reg;
      CUSTOM_HI_ADDR: read_value[3:0] = custom_hi_reg;
      formatter_pkg::STATUS_ADDR: begin
        read_value[formatter_pkg::STATUS_DROP_LSB +: DROP_W] = drop_count_reg;
        read_value[formatter_pkg::STATUS_BUSY_BIT] = busy;
        read_value[formatter_pkg::STATUS_TRAIN_BIT] = (pattern != formatter_pkg::PAT_SAMPLE);
      end
      default: read_value = '0;
    endcase
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_reg <= '0;
    end else if (setup_phase) begin
      prdata_reg <= read_value;
    end
  end

  // Control register; upper bits are not stored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= formatter_pkg::CTRL_RESET;
    end else if (write_strobe && paddr == formatter_pkg::CTRL_ADDR) begin
      ctrl_reg <= pwdata[4:0];
    end
  end

  // Gain register; changing the range bit loads that mode's default pair
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gain_reg <= formatter_pkg::GAIN_FULL_DEFAULT;
    end else if (write_strobe && paddr == formatter_pkg::GAIN_ADDR) begin
      if (pwdata[formatter_pkg::GAIN_RANGE_BIT] != gain_reg[formatter_pkg::GAIN_RANGE_BIT]) begin
        gain_reg <= pwdata[formatter_pkg::GAIN_RANGE_BIT] ?
                    formatter_pkg::GAIN_REDUCED_DEFAULT :
                    formatter_pkg::GAIN_FULL_DEFAULT;
      end else begin
        gain_reg <= pwdata[6:0];
      end
    end
  end

  // Custom pattern registers, low eight and high four bits
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      custom_lo_reg <= '0;
      custom_hi_reg <= '0;
    end else if (write_strobe) begin
      if (paddr == CUSTOM_LO_ADDR) begin
        custom_lo_reg <= pwdata[7:0];
      end
      if (paddr == CUSTOM_HI_ADDR) begin
        custom_hi_reg <= pwdata[3:0];
      end
    end
  end

  // Field views of the control, gain and custom registers
  assign equalizer_on = ctrl_reg[formatter_pkg::CTRL_EQ_BIT];
  assign output_number_format = ctrl_reg[formatter_pkg::CTRL_FMT_BIT];
  assign msb_first = ctrl_reg[formatter_pkg::CTRL_MSB_BIT];
  assign pattern = formatter_pkg::pattern_t'(ctrl_reg[formatter_pkg::CTRL_PAT_LSB +: 2]);
  assign reduced_input_range = gain_reg[formatter_pkg::GAIN_RANGE_BIT];
  assign custom_word = {custom_hi_reg, custom_lo_reg};

  // ****************************************************************
  // Sample path: gain, equalizer, format
  // ****************************************************************
  gain_scaler #(
    .W(W)
  ) gain_scaler_inst (
    .clk(clk),
    .reset_n(reset_n),
    .coarse(gain_reg[formatter_pkg::GAIN_COARSE_LSB +: 3]),
    .fine(gain_reg[formatter_pkg::GAIN_FINE_LSB +: 3]),
    .sample_in(sample_in),
    .sample_out(scaled)
  );

  // Delay stages that the equalizer removes from the path
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      eq_stage1_reg <= '0;
      eq_stage2_reg <= '0;
    end else begin
      eq_stage1_reg <= scaled;
      eq_stage2_reg <= eq_stage1_reg;
    end
  end

  // Equalizer on takes the early tap, two cycles less group delay
  assign picked = equalizer_on ? scaled : eq_stage2_reg;

  // Offset binary is two's complement with the sign bit inverted
  assign formatted = output_number_format ? (picked.data ^ formatter_pkg::OFFSET_FLIP)
                                          : picked.data;

  // ****************************************************************
  // Word hand-off to the link domain
  // ****************************************************************

  // Acknowledge toggle back from the lane side
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      ack_meta_reg <= req_seen_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  assign busy = req_toggle_reg != ack_sync_reg;

  // Source choice: samples, or a training word offered whenever idle
  always_comb begin
    unique case (pattern)
      formatter_pkg::PAT_SAMPLE: send_word = formatted;
      formatter_pkg::PAT_TRAIN1: send_word = formatter_pkg::TRAIN_WORD_1;
      formatter_pkg::PAT_TRAIN2: send_word = formatter_pkg::TRAIN_WORD_2;
      formatter_pkg::PAT_CUSTOM: send_word = custom_word;
    endcase
  end

  assign send = ~busy & ((pattern != formatter_pkg::PAT_SAMPLE) | picked.valid);

  // Hold word stays still until the lane side acknowledges it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hold_reg <= '0;
      req_toggle_reg <= 1'b0;
    end else if (send) begin
      hold_reg.data <= send_word;
      hold_reg.msb_first <= msb_first;
      req_toggle_reg <= ~req_toggle_reg;
    end
  end

  // Samples that meet a busy hand-off are lost; count them for software
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drop_count_reg <= '0;
    end else if (picked.valid && busy && pattern == formatter_pkg::PAT_SAMPLE &&
                 drop_count_reg != '1) begin
      drop_count_reg <= drop_count_reg + 1'b1;
    end
  end

  // ****************************************************************
  // Link domain: serializer on link_clk
  // ****************************************************************

  // Reset brought into the link domain
  always_ff @(posedge link_clk) begin
    rst_meta_reg <= reset_n;
    link_reset_n_reg <= rst_meta_reg;
  end

  // Request toggle synchroniser
  always_ff @(posedge link_clk) begin
    if (!link_reset_n_reg) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
    end else begin
      req_meta_reg <= req_toggle_reg;
      req_sync_reg <= req_meta_reg;
    end
  end

  // Take the held word once the toggle arrives; echo it as acknowledge
  always_ff @(posedge link_clk) begin
    if (!link_reset_n_reg) begin
      req_seen_reg <= 1'b0;
      pending_reg <= '0;
    end else if (req_sync_reg != req_seen_reg) begin
      req_seen_reg <= req_sync_reg;
      pending_reg <= hold_reg;
    end
  end

  // Free-running bit counter, untouched by the pattern select
  assign bit_cnt_next = (bit_cnt_reg == LAST_BIT) ? 4'h0 : bit_cnt_reg + 4'h1;

  // Shifter: load at the word boundary, last word repeats if none new
  always_comb begin
    if (bit_cnt_reg == LAST_BIT) begin
      shift_next = pending_reg.data;
      order_next = pending_reg.msb_first;
    end else if (order_reg) begin
      shift_next = {shift_reg[W-2:0], 1'b0};
      order_next = order_reg;
    end else begin
      shift_next = {1'b0, shift_reg[W-1:1]};
      order_next = order_reg;
    end
  end

  // Lane registers
  always_ff @(posedge link_clk) begin
    if (!link_reset_n_reg) begin
      bit_cnt_reg <= LAST_BIT; // First edge out of reset opens a whole word
      shift_reg <= '0;
      order_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      order_reg <= order_next;
    end
  end

  // Registered lane outputs; word clock high for the first half word
  always_ff @(posedge link_clk) begin
    if (!link_reset_n_reg) begin
      serial_data <= 1'b0;
      word_clk <= 1'b0;
    end else begin
      serial_data <= order_next ? shift_next[W-1] : shift_next[0];
      word_clk <= (bit_cnt_next < HALF_WORD);
    end
  end

endmodule // output_formatter

`default_nettype wire
